// *** src/lpd_consts.svh ***
// constants shared by both ends of the command link
`ifndef LPD_CONSTS_SVH
`define LPD_CONSTS_SVH
// ****************************************
// clock and analog times
// ****************************************
`define LPD_TCK_PS      8000
`define LPD_CYC_UP(ps)  (((ps) + `LPD_TCK_PS - 1) / `LPD_TCK_PS)
`define LPD_TRTP_PS     7500
`define LPD_TWR_PS      15000
`define LPD_TRP_PS      18000
`define LPD_TRAS_PS     42000
`define LPD_RTP_CYC     `LPD_CYC_UP(`LPD_TRTP_PS)
`define LPD_WR_CYC      `LPD_CYC_UP(`LPD_TWR_PS)
`define LPD_RP_CYC      `LPD_CYC_UP(`LPD_TRP_PS)
`define LPD_RAS_CYC     `LPD_CYC_UP(`LPD_TRAS_PS)
// ****************************************
// command codes on the rising-edge field
// ****************************************
`define LPD_CA_BST      4'h3
`define LPD_CA_PRE      4'hB
`define LPD_CA_MRW      4'h0
`define LPD_CA_RD       3'h5
`define LPD_CA_WR       3'h1
`define LPD_CA_ACT      2'h2
// ****************************************
// command field positions
// ****************************************
`define LPD_BA_HI       8
`define LPD_BA_LO       7
`define LPD_AB_BIT      4
`define LPD_AP_BIT      0
`define LPD_COL_HI      4
`define LPD_COL_LO      1
// mode write: burst half on rising field, latencies on falling field
`define LPD_MR_BLH_HI   7
`define LPD_MR_BLH_LO   4
`define LPD_MR_RL_HI    3
`define LPD_MR_RL_LO    0
`define LPD_MR_WL_HI    7
`define LPD_MR_WL_LO    4
`define LPD_RL_RST      4'h6
`define LPD_WL_RST      4'h3
`define LPD_BLH_RST     4'h4
`define LPD_RL_MIN      4'h2
`define LPD_WL_MIN      4'h1
`define LPD_PIPE_DEPTH  16
// ****************************************
// controller register map
// ****************************************
`define LPD_REG_CMD     8'h00
`define LPD_REG_WDATA   8'h04
`define LPD_REG_WMASK   8'h08
`define LPD_REG_RDATA   8'h0C
`define LPD_REG_STAT    8'h10
`define LPD_OP_MRW      3'h0
`define LPD_OP_ACT      3'h1
`define LPD_OP_RD       3'h2
`define LPD_OP_WR       3'h3
`define LPD_OP_PRE      3'h4
`define LPD_RESP_OKAY   2'h0
`define LPD_RESP_SLVERR 2'h2
`endif

// *** src/lpd_pkg.sv ***
// types shared by both ends of the command link
package lpd_pkg;
  // controller sequencer states
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_run  = 2'b01
  } lpd_state_e;
  // one data slot travelling down the latency pipe
  typedef struct packed {
    logic       wr;
    logic [1:0] bank;
    logic [3:0] col;
  } lpd_slot_s;
endpackage

// *** src/lpd_link_if.sv ***
// command/address and data link between controller and memory
`timescale 1ns/1ps
interface lpd_link_if;
  logic        cs_n;   // chip select, low active
  logic [9:0]  ca_r;   // command/address, rising half
  logic [9:0]  ca_f;   // command/address, falling half
  logic [31:0] wdata;  // write beat pair
  logic [3:0]  wmask;  // byte masks, high blocks a byte
  logic [31:0] rdata;  // read beat pair
  logic        rvalid; // read beat pair present
  modport ctl (output cs_n, ca_r, ca_f, wdata, wmask, input rdata, rvalid);
  modport dev (input cs_n, ca_r, ca_f, wdata, wmask, output rdata, rvalid);
endinterface // lpd_link_if

// *** src/lpd_bank_timer.sv ***
// per-bank open state, auto precharge countdown and precharge time
`timescale 1ns/1ps
`include "lpd_consts.svh"
module lpd_bank_timer (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // bank events
  input  wire logic       act,
  input  wire logic       pre,
  input  wire logic       ap_load,
  input  wire logic [5:0] ap_delay,
  // bank state
  output logic            is_open,
  output logic            ready
);
  logic [5:0] ap_cnt;  // cycles left to auto precharge
  logic [3:0] rp_cnt;  // cycles left of precharge time
  wire        ap_fire = (ap_cnt == 6'h01);
  wire        close   = pre | ap_fire;
  // same precharge time whether all-bank or one bank closed it
  assign ready = !is_open && (rp_cnt == 4'h0);
  // ****************************************
  // state update
  // ****************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      is_open <= 1'b0;
      ap_cnt  <= 6'h00;
      rp_cnt  <= 4'h0;
    end else begin
      // activation wins: a clash is a controller fault anyway
      is_open <= act ? 1'b1 : (close ? 1'b0 : is_open);
      ap_cnt  <= ap_load ? ap_delay : (ap_cnt != 6'h00 ? ap_cnt - 6'h01 : 6'h00);
      // latest precharge restarts the period
      rp_cnt  <= close ? 4'(`LPD_RP_CYC) : (rp_cnt != 4'h0 ? rp_cnt - 4'h1 : 4'h0);
    end
  end
endmodule // lpd_bank_timer

// *** src/lpd_dev.sv ***
// memory end: command decode, burst timing, masks, precharge
`timescale 1ns/1ps
`include "lpd_consts.svh"
module lpd_dev (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  rstn,
  // link
  lpd_link_if.dev    lnk,
  // status
  output logic [3:0] bank_open,
  output logic [3:0] bank_ready,
  output logic       bst_drop
);
  // ****************************************
  // command decode
  // ****************************************
  wire       sel     = !lnk.cs_n;
  wire       is_rd   = sel && (lnk.ca_r[2:0] == `LPD_CA_RD);
  wire       is_wr   = sel && (lnk.ca_r[2:0] == `LPD_CA_WR);
  wire       is_acc  = is_rd | is_wr;
  wire       is_bst  = sel && (lnk.ca_r[3:0] == `LPD_CA_BST);
  wire       is_pre  = sel && (lnk.ca_r[3:0] == `LPD_CA_PRE);
  wire       is_act  = sel && (lnk.ca_r[1:0] == `LPD_CA_ACT);
  wire       is_mrw  = sel && (lnk.ca_r[3:0] == `LPD_CA_MRW);
  wire [1:0] c_bank  = lnk.ca_r[`LPD_BA_HI:`LPD_BA_LO];
  wire [3:0] c_col   = lnk.ca_f[`LPD_COL_HI:`LPD_COL_LO];
  wire       c_ap    = lnk.ca_f[`LPD_AP_BIT];
  wire       c_all   = lnk.ca_r[`LPD_AB_BIT];
  // ****************************************
  // mode settings
  // ****************************************
  logic [3:0] rl;   // read latency
  logic [3:0] wl;   // write latency
  logic [3:0] blh;  // burst length over two
  wire [3:0] mr_rl  = lnk.ca_f[`LPD_MR_RL_HI:`LPD_MR_RL_LO];
  wire [3:0] mr_wl  = lnk.ca_f[`LPD_MR_WL_HI:`LPD_MR_WL_LO];
  // the pipe taps need a floor, so tiny latencies are clamped
  wire [3:0] rl_set = (mr_rl < `LPD_RL_MIN) ? `LPD_RL_MIN : mr_rl;
  wire [3:0] wl_set = (mr_wl < `LPD_WL_MIN) ? `LPD_WL_MIN : mr_wl;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rl  <= `LPD_RL_RST;
      wl  <= `LPD_WL_RST;
      blh <= `LPD_BLH_RST;
    end else if (is_mrw) begin
      rl  <= rl_set;
      wl  <= wl_set;
      blh <= lnk.ca_r[`LPD_MR_BLH_HI:`LPD_MR_BLH_LO];
    end
  end
  // ****************************************
  // burst in flight on the command side
  // ****************************************
  logic       acc_on;   // latest access still issuing slots
  logic       acc_wr;
  logic [1:0] acc_bank;
  logic [3:0] acc_col;
  logic [3:0] acc_cnt;  // cycles since the access command
  // terminate only cuts the latest access
  wire bst_hit  = is_bst && acc_on;
  // slot per cycle until terminate: two beats a cycle
  wire run_slot = acc_on && !is_bst && (acc_cnt < blh);
  wire slot_vld = is_acc | run_slot;
  lpd_pkg::lpd_slot_s slot_in;
  assign slot_in = is_acc ? lpd_pkg::lpd_slot_s'({is_wr, c_bank, c_col})
                          : lpd_pkg::lpd_slot_s'({acc_wr, acc_bank, 4'(acc_col + acc_cnt)});
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_on   <= 1'b0;
      acc_wr   <= 1'b0;
      acc_bank <= 2'h0;
      acc_col  <= 4'h0;
      acc_cnt  <= 4'h0;
      bst_drop <= 1'b0;
    end else begin
      bst_drop <= is_bst && !acc_on;
      if (is_acc) begin
        // a new access replaces the old one
        acc_on   <= 1'b1;
        acc_wr   <= is_wr;
        acc_bank <= c_bank;
        acc_col  <= c_col;
        acc_cnt  <= 4'h1;
      end else if (bst_hit) begin
        acc_on   <= 1'b0;
      end else if (acc_on) begin
        acc_on   <= (acc_cnt < blh - 4'h1);
        acc_cnt  <= acc_cnt + 4'h1;
      end
    end
  end
  // ****************************************
  // latency pipe: data lags its slot by rl or wl
  // ****************************************
  logic [`LPD_PIPE_DEPTH-1:0] pv;
  lpd_pkg::lpd_slot_s         ps [`LPD_PIPE_DEPTH];
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pv <= '0;
    end else begin
      pv <= {pv[`LPD_PIPE_DEPTH-2:0], slot_vld};
    end
  end
  always_ff @(posedge clk) begin
    ps[0] <= slot_in;
    for (int i = 1; i < `LPD_PIPE_DEPTH; i++) begin
      ps[i] <= ps[i-1];
    end
  end
  // read tap one early because the output is registered
  wire [3:0] rd_tap = rl - 4'h2;
  wire [3:0] wr_tap = wl - 4'h1;
  wire       rd_go  = pv[rd_tap] && !ps[rd_tap].wr;
  wire       wr_go  = pv[wr_tap] && ps[wr_tap].wr;
  wire [5:0] rd_idx = {ps[rd_tap].bank, ps[rd_tap].col};
  wire [5:0] wr_idx = {ps[wr_tap].bank, ps[wr_tap].col};
  // ****************************************
  // storage and data ports
  // ****************************************
  logic [31:0] mem [64];  // small flop array, one word per bank and column
  always_ff @(posedge clk) begin
    for (int b = 0; b < 4; b++) begin
      // masked bytes keep their old value
      if (wr_go && !lnk.wmask[b]) begin
        mem[wr_idx][8*b +: 8] <= lnk.wdata[8*b +: 8];
      end
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lnk.rvalid <= 1'b0;
      lnk.rdata  <= 32'h0000_0000;
    end else begin
      lnk.rvalid <= rd_go;
      lnk.rdata  <= rd_go ? mem[rd_idx] : 32'h0000_0000;
    end
  end
  // ****************************************
  // banks
  // ****************************************
  // read: later of blh and blh-2+rtp; write: wl+blh+1+wr
  wire [5:0] rtp_end = 6'({2'h0, blh} + 6'(`LPD_RTP_CYC) - 6'h02);
  wire [5:0] rd_ap   = (rtp_end > {2'h0, blh}) ? rtp_end : {2'h0, blh};
  wire [5:0] wr_ap   = 6'({2'h0, wl} + {2'h0, blh} + 6'h01 + 6'(`LPD_WR_CYC));
  for (genvar g = 0; g < 4; g++) begin : g_bank
    lpd_bank_timer u_bank (
      .clk      (clk),
      .rstn     (rstn),
      .act      (is_act && (c_bank == 2'(g))),
      .pre      (is_pre && (c_all || (c_bank == 2'(g)))),
      .ap_load  (is_acc && c_ap && (c_bank == 2'(g))),
      .ap_delay (is_wr ? wr_ap : rd_ap),
      .is_open  (bank_open[g]),
      .ready    (bank_ready[g])
    );
  end
endmodule // lpd_dev

// *** src/lpd_ctl.sv ***
// controller end: AXI4-Lite orders in, spaced commands out
// How it works
// - terminate code: select low, 0011
// - terminate only running bursts, before half length
// - cut length is twice cycles to terminate
// - terminate cuts only the latest access
// - read data stops read latency later
// - write input stops write latency later
// - terminate an even number of cycles after
// - one terminate per access at most
// - spacing uses the cut burst length
// - byte mask blocks writes beat by beat
// - precharge code: select low, 1011
// - all-bank flag or two bank bits
// - same precharge time for one or all
// - precharge after half burst and active time
// - read-to-precharge counted from half minus two
// - write-to-precharge adds latency, recovery, one
// - auto precharge flag closes bank after burst
// - read auto precharge at later of two
// - never issue inside a minimum spacing
// - precharge time from latest precharge
// - auto precharge allows other-bank followers only
// - never cut an auto-precharge access
// - latencies come from mode settings
//
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "lpd_consts.svh"
module lpd_ctl (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // AXI4-Lite write address
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  // AXI4-Lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // AXI4-Lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  // AXI4-Lite read data
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // link
  lpd_link_if.ctl          lnk
);
  // ****************************************
  // write channel capture
  // ****************************************
  logic        aw_hold;  // address taken, waiting for data
  logic [7:0]  aw_q;
  logic        w_hold;   // data taken, waiting for address
  logic [31:0] w_q;
  logic [3:0]  s_q;
  assign awready = !aw_hold;
  assign wready  = !w_hold;
  // both halves in and no response pending
  wire do_wr = aw_hold && w_hold && !bvalid;
  wire wr_cmd = do_wr && (aw_q == `LPD_REG_CMD);
  wire wr_dat = do_wr && (aw_q == `LPD_REG_WDATA);
  wire wr_msk = do_wr && (aw_q == `LPD_REG_WMASK);
  wire wr_ok  = wr_cmd | wr_dat | wr_msk;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_hold <= 1'b0;
      aw_q    <= 8'h00;
      w_hold  <= 1'b0;
      w_q     <= 32'h0000_0000;
      s_q     <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= `LPD_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_hold <= 1'b1;
        aw_q    <= awaddr;
      end else if (do_wr) begin
        aw_hold <= 1'b0;
      end
      if (wvalid && wready) begin
        w_hold <= 1'b1;
        w_q    <= wdata;
        s_q    <= wstrb;
      end else if (do_wr) begin
        w_hold <= 1'b0;
      end
      // addresses other than command, write data and mask answer with a slave error
      if (do_wr) begin
        bvalid <= 1'b1;
        bresp  <= wr_ok ? `LPD_RESP_OKAY : `LPD_RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end
  // ****************************************
  // software registers
  // ****************************************
  logic [31:0] wd_q;   // write beat pair
  logic [3:0]  wm_q;   // write byte masks
  logic [31:0] rd_q;   // last read beat pair
  logic [4:0]  beats;  // read beat pairs seen this order
  logic [27:0] cmd_q;  // order being executed
  lpd_pkg::lpd_state_e st;
  wire busy = (st != lpd_pkg::st_idle);
  // orders written while busy are dropped
  wire launch = wr_cmd && !busy;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wd_q <= 32'h0000_0000;
      wm_q <= 4'h0;
    end else begin
      for (int b = 0; b < 4; b++) begin
        if (wr_dat && s_q[b]) begin
          wd_q[8*b +: 8] <= w_q[8*b +: 8];
        end
      end
      if (wr_msk && s_q[0]) begin
        wm_q <= w_q[3:0];
      end
    end
  end
  // ****************************************
  // read channel
  // ****************************************
  wire [31:0] rd_mux =
    (araddr == `LPD_REG_CMD)   ? {4'h0, cmd_q} :
    (araddr == `LPD_REG_WDATA) ? wd_q :
    (araddr == `LPD_REG_WMASK) ? {28'h0, wm_q} :
    (araddr == `LPD_REG_RDATA) ? rd_q :
    (araddr == `LPD_REG_STAT)  ? {23'h0, beats, 3'h0, busy} : 32'h0000_0000;
  wire rd_ok = (araddr == `LPD_REG_CMD) || (araddr == `LPD_REG_WDATA) ||
               (araddr == `LPD_REG_WMASK) || (araddr == `LPD_REG_RDATA) ||
               (araddr == `LPD_REG_STAT);
  assign arready = !rvalid;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= `LPD_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rd_mux;
      rresp  <= rd_ok ? `LPD_RESP_OKAY : `LPD_RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
  // ****************************************
  // order fields and controller copy of mode
  // ****************************************
  wire [2:0] op    = cmd_q[2:0];
  wire [1:0] bank  = cmd_q[4:3];
  wire       ap    = cmd_q[5];
  wire       all   = cmd_q[6];
  wire [3:0] col   = cmd_q[10:7];
  wire [3:0] stop  = cmd_q[14:11];
  logic [3:0] rl_c;   // read latency as programmed
  logic [3:0] wl_c;   // write latency as programmed
  logic [3:0] blh_c;  // burst length over two
  wire acc  = (op == `LPD_OP_RD) || (op == `LPD_OP_WR);
  // terminate only when legal, else the full burst runs
  wire has_stop = acc && !ap && (stop != 4'h0) && !stop[0] && (stop < blh_c);
  wire [3:0] eff = has_stop ? stop : blh_c;
  // ****************************************
  // spacing: the order owns the link until all gaps pass
  // ****************************************
  logic [6:0] t;  // cycles since the order started
  logic [6:0] guard;
  always_comb begin
    case (op)
      `LPD_OP_RD:  guard = 7'({3'h0, rl_c} + {3'h0, eff} + 7'(`LPD_RTP_CYC)
                              + 7'(`LPD_RP_CYC) + 7'h02);
      `LPD_OP_WR:  guard = 7'({3'h0, wl_c} + {3'h0, eff} + 7'h01 + 7'(`LPD_WR_CYC)
                              + 7'(`LPD_RP_CYC) + 7'h02);
      `LPD_OP_ACT: guard = 7'(`LPD_RAS_CYC);
      `LPD_OP_PRE: guard = 7'(`LPD_RP_CYC) + 7'h01;
      default:     guard = 7'h02;
    endcase
  end
  // single terminate per access, at its fixed offset
  wire bst_at = busy && has_stop && (t == {3'h0, stop});
  wire cmd_at = busy && (t == 7'h00);
  wire [6:0] wl_t  = {3'h0, wl_c};
  wire win = busy && (op == `LPD_OP_WR) && (t >= wl_t) && (t < wl_t + {3'h0, eff});
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st    <= lpd_pkg::st_idle;
      t     <= 7'h00;
      cmd_q <= 28'h0;
      rl_c  <= `LPD_RL_RST;
      wl_c  <= `LPD_WL_RST;
      blh_c <= `LPD_BLH_RST;
    end else begin
      case (st)
        lpd_pkg::st_idle: begin
          if (launch) begin
            st    <= lpd_pkg::st_run;
            t     <= 7'h00;
            cmd_q <= w_q[27:0];
          end
        end
        lpd_pkg::st_run: begin
          t <= t + 7'h01;
          if (cmd_at && op == `LPD_OP_MRW) begin
            rl_c  <= cmd_q[19:16];
            wl_c  <= cmd_q[23:20];
            blh_c <= cmd_q[27:24];
          end
          if (t >= guard) begin
            st <= lpd_pkg::st_idle;
          end
        end
        default: st <= lpd_pkg::st_idle;
      endcase
    end
  end
  // ****************************************
  // command encode
  // ****************************************
  logic [9:0] next_ca_r;
  logic [9:0] next_ca_f;
  always_comb begin
    next_ca_r = 10'h000;
    next_ca_f = 10'h000;
    if (bst_at) begin
      next_ca_r[3:0] = `LPD_CA_BST;
    end else if (cmd_at) begin
      next_ca_r[`LPD_BA_HI:`LPD_BA_LO] = bank;
      case (op)
        `LPD_OP_RD, `LPD_OP_WR: begin
          next_ca_r[2:0] = (op == `LPD_OP_RD) ? `LPD_CA_RD : `LPD_CA_WR;
          next_ca_f[`LPD_AP_BIT] = ap;
          next_ca_f[`LPD_COL_HI:`LPD_COL_LO] = col;
        end
        `LPD_OP_ACT: next_ca_r[1:0] = `LPD_CA_ACT;
        `LPD_OP_PRE: begin
          next_ca_r[3:0] = `LPD_CA_PRE;
          next_ca_r[`LPD_AB_BIT] = all;
        end
        default: begin
          next_ca_r = {2'h0, cmd_q[27:24], `LPD_CA_MRW};
          next_ca_f = {2'h0, cmd_q[23:16]};
        end
      endcase
    end
  end
  // ****************************************
  // link drive and read capture
  // ****************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lnk.cs_n  <= 1'b1;
      lnk.ca_r  <= 10'h000;
      lnk.ca_f  <= 10'h000;
      lnk.wdata <= 32'h0000_0000;
      lnk.wmask <= 4'hF;
      rd_q      <= 32'h0000_0000;
      beats     <= 5'h00;
    end else begin
      lnk.cs_n  <= !(cmd_at || bst_at);
      lnk.ca_r  <= next_ca_r;
      lnk.ca_f  <= next_ca_f;
      lnk.wdata <= wd_q;
      // outside the window every byte is masked, a safe idle value
      lnk.wmask <= win ? wm_q : 4'hF;
      if (launch) begin
        beats <= 5'h00;
      end else if (lnk.rvalid) begin
        rd_q  <= lnk.rdata;
        beats <= beats + 5'h01;
      end
    end
  end
endmodule // lpd_ctl

// *** dv/lpd_link_properties.sv ***
// timing checks on the command link between controller and memory
`timescale 1ns/1ps
module lpd_link_properties (
  // clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // link signals
  input wire logic        cs_n,
  input wire logic [9:0]  ca_r,
  input wire logic [9:0]  ca_f,
  input wire logic [31:0] wdata,
  input wire logic [3:0]  wmask,
  input wire logic [31:0] rdata,
  input wire logic        rvalid
);
  // ****************************************
  // decode, valid for reset mode only (rl 6, wl 3, bl 8)
  // ****************************************
  wire acc = !cs_n && ca_r[1:0] == 2'h1;    // read or write
  wire rd  = acc && ca_r[2];                // read
  wire wr  = acc && !ca_r[2];               // write
  wire burst_terminate = !cs_n && ca_r[3:0] == 4'h3;    // terminate
  wire pre = !cs_n && ca_r[3:0] == 4'hB;    // precharge
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  cmd_pulse_a: assert property (!cs_n |=> cs_n)
    else $error("command select held two cycles");
  acc_gap_a: assert property (acc |=> !acc [*3])
    else $error("accesses too close");
  bst_even_a: assert property (burst_terminate |-> $past(acc, 2))
    else $error("terminate not two cycles after access");
  bst_once_a: assert property (burst_terminate |=> !burst_terminate [*8])
    else $error("second terminate for one access");
  ap_nocut_a: assert property (acc && ca_f[0] |=> !burst_terminate [*8])
    else $error("auto precharge access terminated");
  rd_lat_a: assert property (rd |-> ##6 rvalid)
    else $error("read data not at read latency");
  rd_cut_a: assert property (rd ##2 burst_terminate |-> ##4 rvalid [*2] ##1 !rvalid)
    else $error("cut read length wrong");
  rd_full_a: assert property (rd ##1 !burst_terminate ##1 !burst_terminate |-> ##4 rvalid [*4] ##1 !rvalid)
    else $error("full read length wrong");
  wr_cut_a: assert property (wr ##2 burst_terminate |-> ##3 wmask == 4'hF)
    else $error("write window not cut");
  wr_early_a: assert property (wr |=> wmask == 4'hF [*2])
    else $error("mask active before write latency");
  cover property (rd ##2 burst_terminate);
  cover property (wr ##2 burst_terminate);
  cover property (pre && ca_r[4]);
endmodule // lpd_link_properties

// *** dv/tb_top.sv ***
// testbench: controller and memory joined, driven over the register bus
`timescale 1ns/1ps
module tb_top;
  // ****************************************
  // bus signals and bookkeeping
  // ****************************************
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  wire logic   awready, wready, bvalid, arready, rvalid;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [3:0]  bank_open, bank_ready;
  integer      mismatches = 0;
  integer      total_checks = 0;
  logic [31:0] d;      // last read word
  logic [1:0]  r;      // last response
  logic [4:0]  b1;     // beat pairs of the latest order
  always #4 clk = ~clk;
  lpd_link_if lpd_link_if_inst ();
  lpd_ctl lpd_ctl_inst (.clk(clk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .lnk(lpd_link_if_inst));
  lpd_dev lpd_dev_inst (.clk(clk), .rstn(rstn), .lnk(lpd_link_if_inst),
    .bank_open(bank_open), .bank_ready(bank_ready), .bst_drop());
  lpd_link_properties lpd_link_properties_inst (.clk(clk), .rstn(rstn),
    .cs_n(lpd_link_if_inst.cs_n), .ca_r(lpd_link_if_inst.ca_r),
    .ca_f(lpd_link_if_inst.ca_f), .wdata(lpd_link_if_inst.wdata),
    .wmask(lpd_link_if_inst.wmask), .rdata(lpd_link_if_inst.rdata),
    .rvalid(lpd_link_if_inst.rvalid));
  // ****************************************
  // reporting and bus tasks
  // ****************************************
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // a hung handshake ends the run as a failure
  task tmo;
    mismatches++;
    give_verdict;
  endtask
  task axi_wr(input logic [7:0] a, input logic [31:0] v);
    integer n;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    r = bresp;
    if (n == 40) tmo;
  endtask
  task axi_rd(input logic [7:0] a);
    integer n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    if (n == 40) tmo;
  endtask
  // order one command, mode fields kept at reset values, then wait out busy
  task cmd(input logic [2:0] op, input logic [1:0] bk, input logic ap, input logic all,
           input logic [3:0] off);
    integer k;
    axi_wr(8'h00, {4'h0, 4'h4, 4'h3, 4'h6, 1'b0, off, 4'h0, all, ap, bk, op});
    for (k = 0; k < 40; k++) begin
      axi_rd(8'h10);
      if (d[0] === 1'b0) break;
    end
    if (k == 40) tmo;
  endtask
  // the beat count restarts at every order, so it is read once afterwards
  task rd_len(input logic ap, input logic [3:0] off, input logic [4:0] exp);
    cmd(3'h2, 2'h1, ap, 1'b0, off);
    axi_rd(8'h10);
    b1 = d[8:4];
    chk(32'(b1), 32'(exp));
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_regs;
    axi_wr(8'h14, 32'h1);
    chk(32'(r), 32'h2);
    axi_wr(8'h10, 32'h1);
    chk(32'(r), 32'h2);
    axi_rd(8'h14);
    chk(32'(r), 32'h2);
    chk(d, 32'h0);
    $display("test regs done");
  endtask
  task t_bank;
    cmd(3'h0, 2'h0, 1'b0, 1'b0, 4'h0);
    for (int b = 0; b < 4; b++) cmd(3'h1, 2'(b), 1'b0, 1'b0, 4'h0);
    chk(32'(bank_open), 32'hF);
    cmd(3'h4, 2'h2, 1'b0, 1'b0, 4'h0);
    chk(32'(bank_open), 32'hB);
    cmd(3'h4, 2'h0, 1'b0, 1'b1, 4'h0);
    chk(32'(bank_open), 32'h0);
    chk(32'(bank_ready), 32'hF);
    $display("test bank done");
  endtask
  task t_data;
    cmd(3'h1, 2'h1, 1'b0, 1'b0, 4'h0);
    axi_wr(8'h04, 32'hA5C31E7F);
    axi_wr(8'h08, 32'h5);
    cmd(3'h3, 2'h1, 1'b0, 1'b0, 4'h0);
    rd_len(1'b0, 4'h0, 5'h4);
    axi_rd(8'h0C);
    chk(d & 32'hFF00FF00, 32'hA5001E00);
    rd_len(1'b0, 4'h2, 5'h2);
    rd_len(1'b0, 4'h3, 5'h4);
    chk(32'(bank_open[1]), 32'h1);
    cmd(3'h3, 2'h1, 1'b0, 1'b0, 4'h2);
    rd_len(1'b1, 4'h2, 5'h4);
    chk(32'(bank_open[1]), 32'h0);
    $display("test data done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_regs;
    t_bank;
    t_data;
    give_verdict;
  end
endmodule // tb_top
